// ---- logic/dtb_pkg.sv ----
// Constants and carrier types of the debug trace buffers block
package dtb_pkg;

    // Trace storage geometry
    localparam int DTB_LINES   = 16;
    localparam int DTB_IDX_W   = 4;
    localparam int DTB_LINE_W  = 128;

    // Register offsets within one processor's map
    localparam logic [23:0] DTB_OFS_DEBUG_CONTROL = 24'h000000;
    localparam logic [23:0] DTB_OFS_TIME_TAG      = 24'h000008;
    localparam logic [23:0] DTB_OFS_BREAK_STEP    = 24'h000020;
    localparam logic [23:0] DTB_OFS_MODE_MASK     = 24'h000024;
    localparam logic [23:0] DTB_OFS_BT_CTRL       = 24'h000040;
    localparam logic [23:0] DTB_OFS_BT_INDEX      = 24'h000044;
    localparam logic [23:0] DTB_OFS_BP_ADDR1      = 24'h000050;
    localparam logic [23:0] DTB_OFS_BP_MASK1      = 24'h000054;
    localparam logic [23:0] DTB_OFS_IT_CTRL       = 24'h110000;

    // Address fields
    localparam int DTB_CPU_HI    = 27;
    localparam int DTB_CPU_LO    = 24;
    localparam logic [3:0] DTB_CPU_SELF = 4'h0;
    localparam int DTB_REGION_HI = 23;
    localparam int DTB_REGION_LO = 16;
    localparam logic [7:0] DTB_REGION_REGS   = 8'h00;
    localparam logic [7:0] DTB_REGION_IT_BUF = 8'h10;
    localparam logic [7:0] DTB_REGION_BT_BUF = 8'h20;
    localparam int DTB_LINE_LO   = 4;
    localparam int DTB_WORD_HI   = 3;
    localparam int DTB_WORD_LO   = 2;

    // Control register fields
    localparam int DTB_CTRL_EN   = 0;
    localparam int DTB_IDX_LO    = 4;

    // Bus trace line fields
    localparam int DTB_BT_BP_HIT   = 127;
    localparam int DTB_TAG_HI      = 125;
    localparam int DTB_TAG_LO      = 96;
    localparam int DTB_BT_IRQ_HI   = 94;
    localparam int DTB_BT_IRQ_LO   = 80;
    localparam int DTB_BT_WRITE    = 79;
    localparam int DTB_BT_TRANS_HI = 78;
    localparam int DTB_BT_TRANS_LO = 77;
    localparam int DTB_BT_SIZE_HI  = 76;
    localparam int DTB_BT_SIZE_LO  = 74;
    localparam int DTB_BT_BURST_HI = 73;
    localparam int DTB_BT_BURST_LO = 71;
    localparam int DTB_BT_MAST_HI  = 70;
    localparam int DTB_BT_MAST_LO  = 67;
    localparam int DTB_BT_LOCK     = 66;
    localparam int DTB_BT_RESP_HI  = 65;
    localparam int DTB_BT_RESP_LO  = 64;
    localparam int DTB_DATA_HI     = 63;
    localparam int DTB_DATA_LO     = 32;
    localparam int DTB_ADDR_HI     = 31;
    localparam int DTB_ADDR_LO     = 0;

    // Instruction trace line fields
    localparam int DTB_IT_MULTI    = 126;
    localparam int DTB_IT_PARAM_HI = 95;
    localparam int DTB_IT_PARAM_LO = 64;
    localparam int DTB_IT_PC_HI    = 63;
    localparam int DTB_IT_PC_LO    = 34;
    localparam int DTB_IT_TRAP     = 33;
    localparam int DTB_IT_ERR      = 32;

    localparam logic [1:0] DTB_HRESP_OKAY = 2'h0;
    localparam int DTB_HTRANS_ACTIVE = 1;

    typedef enum logic [2:0] {
        DTB_K_SINGLE     = 3'h0,
        DTB_K_STORE      = 3'h1,
        DTB_K_STORE_DBL  = 3'h2,
        DTB_K_LOAD_DBL   = 3'h3,
        DTB_K_MULDIV     = 3'h4,
        DTB_K_FP_DBL     = 3'h5
    } dtb_kind_type;

    typedef enum logic {
        DTB_PH_ADDR = 1'b0,
        DTB_PH_DATA = 1'b1
    } dtb_phase_type;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic        hready;
        logic [31:0] hwdata;
    } dtb_ahbs_in_type;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [2:0]  hburst;
        logic [3:0]  hmaster;
        logic        hmastlock;
        logic        hready;
        logic [1:0]  hresp;
        logic [31:0] hrdata;
        logic [31:0] hwdata;
        logic [15:0] hirq;
    } dtb_mon_type;

    typedef struct packed {
        logic         valid;
        logic         first;
        dtb_kind_type kind;
        logic [31:0]  pc;
        logic [31:0]  opcode;
        logic         trap;
        logic         err;
        logic [31:0]  param;
    } dtb_inst_type;

endpackage : dtb_pkg

// ---- logic/dtb_debug_trace_buffers.sv ----
// Bus and instruction trace capture of the debug support unit
`timescale 1ns/1ps

module dtb_debug_trace_buffers
    import dtb_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire dtb_ahbs_in_type ahbs_in,
    output logic                 hreadyout,
    output logic [1:0]           hresp,
    output logic [31:0]          hrdata,
    input  wire dtb_mon_type     bus_mon,
    input  wire logic            bus_bp_hit,
    input  wire logic            cpu_debug_mode,
    input  wire dtb_inst_type    inst_in,
    output logic [31:0]          debug_control
);

    typedef logic [DTB_LINES-1:0][DTB_LINE_W-1:0] dtb_mem_type;

    typedef struct packed {
        dtb_phase_type        phase;
        logic                 a_write;
        logic [31:0]          a_addr;
        logic                 ready;
        logic [1:0]           resp;
        logic [31:0]          rdata;
        logic [31:0]          dbg_ctrl;
        logic [31:0]          time_tag;
        logic [31:0]          brk_step;
        logic [31:0]          mode_mask;
        logic                 bt_en;
        logic [DTB_IDX_W-1:0] bt_idx;
        logic [31:0]          bp_addr;
        logic [31:0]          bp_mask;
        logic                 it_en;
        logic [DTB_IDX_W-1:0] it_idx;
        logic                 pend;
        dtb_mon_type          pend_mon;
        logic [1:0]           inst_cnt;
        dtb_kind_type         inst_kind;
        dtb_mem_type          bt_mem;
        dtb_mem_type          it_mem;
    } dtb_state_type;

    dtb_state_type q, d;

    // Word 0 holds the top bits of a line
    function automatic logic [31:0] dtb_get_word(
        input logic [DTB_LINE_W-1:0] line,
        input logic [1:0]            word
    );
        logic [1:0] sel;
        sel = 2'h3 - word;
        return line[sel*32 +: 32];
    endfunction : dtb_get_word

    function automatic logic [DTB_LINE_W-1:0] dtb_put_word(
        input logic [DTB_LINE_W-1:0] line,
        input logic [1:0]            word,
        input logic [31:0]           value
    );
        logic [DTB_LINE_W-1:0] res;
        logic [1:0]            sel;
        res = line;
        sel = 2'h3 - word;
        res[sel*32 +: 32] = value;
        return res;
    endfunction : dtb_put_word

    function automatic logic [1:0] dtb_last_instance(input dtb_kind_type k);
        unique case (k)
            DTB_K_SINGLE:    return 2'h0;
            DTB_K_STORE_DBL: return 2'h2;
            default:         return 2'h1;
        endcase
    endfunction : dtb_last_instance

    function automatic logic [31:0] dtb_idx_reg(
        input logic                 en,
        input logic [DTB_IDX_W-1:0] idx
    );
        logic [31:0] r;
        r = 32'h0;
        r[DTB_CTRL_EN] = en;
        r[DTB_IDX_LO +: DTB_IDX_W] = idx;
        return r;
    endfunction : dtb_idx_reg

    // Locals of the next-state process
    logic [23:0]           ofs;
    logic [7:0]            region;
    logic [DTB_IDX_W-1:0]  line;
    logic [1:0]            word;
    logic                  mine;
    logic                  bt_open;
    logic                  it_open;
    logic [31:0]           rd;
    logic                  bt_active;
    logic                  it_active;
    logic [DTB_LINE_W-1:0] bt_line;
    logic [DTB_LINE_W-1:0] it_line;
    logic [1:0]            inst_no;
    dtb_kind_type          inst_k;
    logic                  bp_stop;

    always_comb
    begin
        d         = q;
        ofs       = q.a_addr[23:0];
        region    = q.a_addr[DTB_REGION_HI:DTB_REGION_LO];
        line      = q.a_addr[DTB_LINE_LO +: DTB_IDX_W];
        word      = q.a_addr[DTB_WORD_HI:DTB_WORD_LO];
        mine      = q.a_addr[DTB_CPU_HI:DTB_CPU_LO] == DTB_CPU_SELF;
        bt_open   = !q.bt_en;
        it_open   = cpu_debug_mode;
        rd        = 32'h0;
        bt_line   = '0;
        it_line   = '0;
        inst_no   = 2'h0;
        inst_k    = DTB_K_SINGLE;
        bp_stop   = 1'b0;
        bt_active = q.bt_en && !cpu_debug_mode;
        it_active = q.it_en && !cpu_debug_mode;

        // Timers freeze in debug mode, so does the time tag
        if (!cpu_debug_mode)
        begin
            d.time_tag = q.time_tag + 32'h1;
        end

        // Bus slave: one wait state so read data leaves a flop
        d.ready = 1'b1;
        d.resp  = DTB_HRESP_OKAY;
        unique case (q.phase)
            DTB_PH_ADDR:
            begin
                if (ahbs_in.hsel && ahbs_in.hready &&
                    ahbs_in.htrans[DTB_HTRANS_ACTIVE])
                begin
                    d.phase   = DTB_PH_DATA;
                    d.a_write = ahbs_in.hwrite;
                    d.a_addr  = ahbs_in.haddr;
                    d.ready   = 1'b0;
                end
            end
            DTB_PH_DATA:
            begin
                d.phase = DTB_PH_ADDR;
                if (mine && region == DTB_REGION_BT_BUF && bt_open)
                begin
                    rd = dtb_get_word(q.bt_mem[line], word);
                    if (q.a_write)
                    begin
                        d.bt_mem[line] = dtb_put_word(q.bt_mem[line], word,
                                                      ahbs_in.hwdata);
                    end
                end
                else if (mine && region == DTB_REGION_IT_BUF && it_open)
                begin
                    rd = dtb_get_word(q.it_mem[line], word);
                    if (q.a_write)
                    begin
                        d.it_mem[line] = dtb_put_word(q.it_mem[line], word,
                                                      ahbs_in.hwdata);
                    end
                end
                else if (mine && ofs == DTB_OFS_IT_CTRL && it_open)
                begin
                    rd = dtb_idx_reg(q.it_en, q.it_idx);
                    if (q.a_write)
                    begin
                        d.it_en  = ahbs_in.hwdata[DTB_CTRL_EN];
                        d.it_idx = ahbs_in.hwdata[DTB_IDX_LO +: DTB_IDX_W];
                    end
                end
                else if (mine && region == DTB_REGION_REGS)
                begin
                    unique case (ofs)
                        DTB_OFS_DEBUG_CONTROL:
                        begin
                            rd = q.dbg_ctrl;
                            if (q.a_write)
                            begin
                                d.dbg_ctrl = ahbs_in.hwdata;
                            end
                        end
                        DTB_OFS_TIME_TAG:
                        begin
                            rd = q.time_tag;
                            if (q.a_write)
                            begin
                                d.time_tag = ahbs_in.hwdata;
                            end
                        end
                        DTB_OFS_BREAK_STEP:
                        begin
                            rd = q.brk_step;
                            if (q.a_write)
                            begin
                                d.brk_step = ahbs_in.hwdata;
                            end
                        end
                        DTB_OFS_MODE_MASK:
                        begin
                            rd = q.mode_mask;
                            if (q.a_write)
                            begin
                                d.mode_mask = ahbs_in.hwdata;
                            end
                        end
                        DTB_OFS_BT_CTRL:
                        begin
                            rd = dtb_idx_reg(q.bt_en, '0);
                            if (q.a_write)
                            begin
                                d.bt_en = ahbs_in.hwdata[DTB_CTRL_EN];
                            end
                        end
                        DTB_OFS_BT_INDEX:
                        begin
                            rd = dtb_idx_reg(1'b0, q.bt_idx);
                            if (q.a_write)
                            begin
                                d.bt_idx =
                                    ahbs_in.hwdata[DTB_IDX_LO +: DTB_IDX_W];
                            end
                        end
                        DTB_OFS_BP_ADDR1:
                        begin
                            if (bt_open)
                            begin
                                rd = q.bp_addr;
                                if (q.a_write)
                                begin
                                    d.bp_addr = ahbs_in.hwdata;
                                end
                            end
                        end
                        DTB_OFS_BP_MASK1:
                        begin
                            if (bt_open)
                            begin
                                rd = q.bp_mask;
                                if (q.a_write)
                                begin
                                    d.bp_mask = ahbs_in.hwdata;
                                end
                            end
                        end
                        default:
                        begin
                            rd = 32'h0;
                        end
                    endcase
                end
                d.rdata = rd;
            end
        endcase

        // Bus capture: address phase held until its data phase ends
        if (bus_mon.hready)
        begin
            if (q.pend && bt_active)
            begin
                bt_line[DTB_BT_BP_HIT] = bus_bp_hit;
                bt_line[DTB_TAG_HI:DTB_TAG_LO] =
                    q.time_tag[DTB_TAG_HI-DTB_TAG_LO:0];
                bt_line[DTB_BT_IRQ_HI:DTB_BT_IRQ_LO] =
                    bus_mon.hirq[15:1];
                bt_line[DTB_BT_WRITE] = q.pend_mon.hwrite;
                bt_line[DTB_BT_TRANS_HI:DTB_BT_TRANS_LO] =
                    q.pend_mon.htrans;
                bt_line[DTB_BT_SIZE_HI:DTB_BT_SIZE_LO] = q.pend_mon.hsize;
                bt_line[DTB_BT_BURST_HI:DTB_BT_BURST_LO] =
                    q.pend_mon.hburst;
                bt_line[DTB_BT_MAST_HI:DTB_BT_MAST_LO] = q.pend_mon.hmaster;
                bt_line[DTB_BT_LOCK] = q.pend_mon.hmastlock;
                bt_line[DTB_BT_RESP_HI:DTB_BT_RESP_LO] = bus_mon.hresp;
                bt_line[DTB_DATA_HI:DTB_DATA_LO] = q.pend_mon.hwrite ?
                    bus_mon.hwdata : bus_mon.hrdata;
                bt_line[DTB_ADDR_HI:DTB_ADDR_LO] = q.pend_mon.haddr;
                d.bt_mem[q.bt_idx] = bt_line;
                d.bt_idx = DTB_IDX_W'(q.bt_idx + 1'b1);
                bp_stop  = bus_bp_hit;
            end
            d.pend     = bus_mon.htrans[DTB_HTRANS_ACTIVE];
            d.pend_mon = bus_mon;
        end

        // Hardware stop outranks a software write of the enable bit
        if (bp_stop)
        begin
            d.bt_en = 1'b0;
        end

        // Instruction capture, one entry per pipeline report up to the instruction's last entry
        if (inst_in.valid)
        begin
            inst_no = inst_in.first ? 2'h0 : 2'(q.inst_cnt + 1'b1);
            inst_k  = inst_in.first ? inst_in.kind : q.inst_kind;
            d.inst_cnt  = inst_no;
            d.inst_kind = inst_k;
            // Reports past the instruction's last entry are dropped
            if (it_active && inst_no <= dtb_last_instance(inst_k))
            begin
                it_line[DTB_IT_MULTI] = inst_no != 2'h0;
                it_line[DTB_TAG_HI:DTB_TAG_LO] =
                    q.time_tag[DTB_TAG_HI-DTB_TAG_LO:0];
                // Store, double load and float results pass as reported
                it_line[DTB_IT_PARAM_HI:DTB_IT_PARAM_LO] =
                    (inst_k == DTB_K_MULDIV && inst_no == 2'h0) ?
                    32'h0 : inst_in.param;
                it_line[DTB_IT_PC_HI:DTB_IT_PC_LO] = inst_in.pc[31:2];
                it_line[DTB_IT_TRAP] = inst_in.trap;
                it_line[DTB_IT_ERR]  = inst_in.err;
                it_line[DTB_ADDR_HI:DTB_ADDR_LO] = inst_in.opcode;
                d.it_mem[q.it_idx] = it_line;
                d.it_idx = DTB_IDX_W'(q.it_idx + 1'b1);
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // Ready must read high out of reset for the bus to start
    logic ready_q;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ready_q <= 1'b1;
        end
        else
        begin
            ready_q <= d.ready;
        end
    end

    assign hreadyout     = ready_q;
    assign hresp         = q.resp;
    assign hrdata        = q.rdata;
    assign debug_control = q.dbg_ctrl;

endmodule : dtb_debug_trace_buffers

// ---- testbench/dtb_checker_asserts.sv ----
// Port assertions for the debug trace buffers
`timescale 1ns/1ps
module dtb_checker_asserts
    import dtb_pkg::*;
(
    input wire logic            ref_clk,
    input wire logic            rst,
    input wire dtb_ahbs_in_type ahbs_in,
    input wire logic            hreadyout,
    input wire logic [1:0]      hresp,
    input wire logic [31:0]     hrdata,
    input wire logic            cpu_debug_mode,
    input wire logic [31:0]     debug_control
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_take;
        ahbs_in.hsel && ahbs_in.hready && ahbs_in.htrans[1] && hreadyout;
    endsequence
    sequence s_rd;
        s_take ##0 !ahbs_in.hwrite;
    endsequence
    // Write data arrives in the wait cycle, not with the address
    property p_ctl;
        logic [31:0] v;
        s_take ##0 (ahbs_in.hwrite && ahbs_in.haddr[27:0] == 28'h0)
            ##1 (1'b1, v = ahbs_in.hwdata) |-> ##1 debug_control == v;
    endproperty
    AST_WAIT: assert property (s_take |=> !hreadyout)
        else $error("no wait state");
    AST_ONE_WAIT: assert property (!hreadyout |=> hreadyout)
        else $error("wait too long");
    AST_IDLE: assert property (hreadyout && !(ahbs_in.hsel && ahbs_in.hready && ahbs_in.htrans[1]) |=> hreadyout)
        else $error("spurious wait");
    AST_OKAY: assert property (hresp == 2'h0)
        else $error("bad response");
    AST_HOLD: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    AST_CPU_SEL: assert property (s_rd ##0 ahbs_in.haddr[27:24] != 4'h0 |-> ##2 hrdata == 32'h0)
        else $error("other cpu answered");
    AST_IT_LOCK: assert property (s_rd ##0 (ahbs_in.haddr[23:16] == 8'h10 && !cpu_debug_mode) |-> ##2 hrdata == 32'h0)
        else $error("trace read outside debug");
    AST_CTL_WR: assert property (p_ctl)
        else $error("control write lost");
endmodule : dtb_checker_asserts

bind dtb_debug_trace_buffers dtb_checker_asserts u_asr (.ref_clk(ref_clk),
    .rst(rst), .ahbs_in(ahbs_in), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu_debug_mode(cpu_debug_mode),
    .debug_control(debug_control));

// ---- testbench/dtb_bus_model.sv ----
// Snooped bus traffic and breakpoint source
`timescale 1ns/1ps
module dtb_bus_model
    import dtb_pkg::*;
(
    input  wire logic   ref_clk,
    output dtb_mon_type mon,
    output logic        bp_hit
);
    initial
    begin
        mon = '{32'h0, 2'h0, 1'b0, 3'h2, 3'h1, 4'h5, 1'b1, 1'b1, 2'h0,
                32'h0, 32'h0, 16'ha5a4};
        bp_hit = 1'b0;
    end
    // Address phase of i overlaps data phase of i-1, zero wait states
    task automatic burst(int n, logic [31:0] b, logic hit);
        for (int i = 0; i <= n; i++)
        begin
            @(posedge ref_clk);
            mon.htrans <= (i < n) ? 2'h2 : 2'h0;
            mon.haddr <= b + 32'(4 * i);
            mon.hwrite <= i[0];
            mon.hrdata <= b ^ 32'(i - 1);
            mon.hwdata <= ~(b ^ 32'(i - 1));
            bp_hit <= hit && i == n;
        end
        // Released data lines must not keep the last value
        @(posedge ref_clk);
        mon.hrdata <= ~mon.hrdata;
        mon.hwdata <= ~mon.hwdata;
        bp_hit <= 1'b0;
    endtask : burst
endmodule : dtb_bus_model

// ---- testbench/test_debug_trace_buffers.sv ----
// Self-checking bench for the debug trace buffers
`timescale 1ns/1ps
module test_debug_trace_buffers
    import dtb_pkg::*;
;
    logic            ref_clk = 1'b0;
    logic            rst = 1'b1;
    dtb_ahbs_in_type ahbs_in = '{1'b0, 32'h0, 2'h0, 1'b0, 1'b1, 32'h0};
    logic            hreadyout;
    logic [1:0]      hresp;
    logic [31:0]     hrdata;
    logic [31:0]     debug_control;
    logic [31:0]     rd;
    logic [31:0]     t;
    dtb_mon_type     bus_mon;
    logic            bus_bp_hit;
    logic            cpu_debug_mode = 1'b0;
    dtb_inst_type    inst_in = '0;
    int              miscompares = 0;
    int              n_tests = 0;
    logic [31:0]     ofs [5] = '{32'h0, 32'h20, 32'h24, 32'h50, 32'h54};
    always #2.5 ref_clk = ~ref_clk;
    dtb_debug_trace_buffers dut (.ref_clk(ref_clk), .rst(rst),
        .ahbs_in(ahbs_in), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .bus_mon(bus_mon), .bus_bp_hit(bus_bp_hit),
        .cpu_debug_mode(cpu_debug_mode), .inst_in(inst_in),
        .debug_control(debug_control));
    dtb_bus_model bm (.ref_clk(ref_clk), .mon(bus_mon), .bp_hit(bus_bp_hit));
    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic acc(logic w, logic [31:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        ahbs_in <= '{1'b1, a, 2'h2, w, 1'b1, 32'h0};
        @(posedge ref_clk);
        ahbs_in <= '{1'b0, a, 2'h0, w, 1'b0, d};
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        while (hreadyout !== 1'b1 && n < 8);
        if (hreadyout !== 1'b1)
        begin
            miscompares++;
            stop_test();
        end
        else
        begin
            rd = hrdata;
            ahbs_in.hready <= 1'b1;
        end
    endtask : acc
    task automatic rc(logic [31:0] a, logic [31:0] m, logic [31:0] e);
        acc(1'b0, a, 32'h0);
        check($sformatf("word at %h", a), rd & m, e);
    endtask : rc
    task automatic ins(logic f, dtb_kind_type k, logic [31:0] p);
        @(posedge ref_clk);
        inst_in <= '{1'b1, f, k, 32'h4000_0000 | (p << 2), ~p, p[0], p[1], p};
    endtask : ins
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            rc(ofs[i], '1, 32'h0);
            acc(1'b1, ofs[i], ~ofs[i]);
            rc(ofs[i], '1, ~ofs[i]);
        end
        rc(32'h0100_0000, '1, 32'h0);
        rc(32'h0c, '1, 32'h0);
        $display("test registers done");
        acc(1'b1, 32'h44, 32'he0);
        acc(1'b1, 32'h40, 32'h1);
        rc(32'h200000, '1, 32'h0);
        rc(32'h50, '1, 32'h0);
        bm.burst(3, 32'h1000_0000, 1'b0);
        acc(1'b1, 32'h40, 32'h0);
        rc(32'h44, '1, 32'h10);
        for (int k = 0; k < 3; k++)
        begin
            t = 32'h200000 + 32'(((14 + k) % 16) * 16);
            rc(t + 12, '1, 32'h1000_0000 + 32'(4 * k));
            rc(t + 8, '1, {32{k[0]}} ^ 32'h1000_0000 ^ 32'(k));
            rc(t + 4, '1, {1'b0, 15'h52d2, k[0], 2'h2, 3'h2, 3'h1, 4'h5, 3'h4});
            rc(t, 32'hc000_0000, 32'h0);
        end
        acc(1'b0, 32'h2000e0, 32'h0);
        t = rd;
        rc(32'h2000f0, 32'h3fff_ffff, (t + 32'h1) & 32'h3fff_ffff);
        acc(1'b1, 32'h40, 32'h1);
        bm.burst(1, 32'h2000_0000, 1'b1);
        rc(32'h40, 32'h1, 32'h0);
        bm.burst(1, 32'h2000_0000, 1'b0);
        rc(32'h44, '1, 32'h20);
        rc(32'h200010, 32'h8000_0000, 32'h8000_0000);
        acc(1'b1, 32'h40, 32'h1);
        cpu_debug_mode <= 1'b1;
        bm.burst(2, 32'h3000_0000, 1'b0);
        cpu_debug_mode <= 1'b0;
        bm.burst(1, 32'h3000_0000, 1'b0);
        acc(1'b1, 32'h40, 32'h0);
        rc(32'h44, '1, 32'h30);
        $display("test bus trace done");
        cpu_debug_mode <= 1'b1;
        acc(1'b1, 32'h110000, 32'h1);
        cpu_debug_mode <= 1'b0;
        ins(1'b1, DTB_K_SINGLE, 32'h11);
        ins(1'b0, DTB_K_SINGLE, 32'h12);
        ins(1'b1, DTB_K_STORE_DBL, 32'h21);
        ins(1'b0, DTB_K_STORE_DBL, 32'h22);
        ins(1'b0, DTB_K_STORE_DBL, 32'h23);
        ins(1'b1, DTB_K_MULDIV, 32'h31);
        ins(1'b0, DTB_K_MULDIV, 32'h32);
        ins(1'b1, DTB_K_FP_DBL, 32'h41);
        ins(1'b0, DTB_K_FP_DBL, 32'h42);
        ins(1'b1, DTB_K_LOAD_DBL, 32'h51);
        ins(1'b0, DTB_K_LOAD_DBL, 32'h52);
        ins(1'b1, DTB_K_STORE, 32'h61);
        ins(1'b0, DTB_K_STORE, 32'h62);
        @(posedge ref_clk);
        inst_in.valid <= 1'b0;
        rc(32'h100008, '1, 32'h0);
        cpu_debug_mode <= 1'b1;
        rc(32'h110000, '1, 32'hc1);
        rc(32'h10000c, '1, ~32'h11);
        rc(32'h100008, '1, 32'h4000_0046);
        rc(32'h100028, '1, 32'h4000_0089);
        rc(32'h100004, '1, 32'h11);
        rc(32'h100010, 32'hc000_0000, 32'h0);
        rc(32'h100034, '1, 32'h23);
        rc(32'h100020, 32'hc000_0000, 32'h4000_0000);
        rc(32'h100044, '1, 32'h0);
        rc(32'h100054, '1, 32'h32);
        rc(32'h100074, '1, 32'h42);
        rc(32'h100064, '1, 32'h41);
        rc(32'h100094, '1, 32'h52);
        rc(32'h100084, '1, 32'h51);
        rc(32'h1000a4, '1, 32'h61);
        rc(32'h1000b0, 32'h4000_0000, 32'h4000_0000);
        acc(1'b0, 32'h100010, 32'h0);
        t = rd;
        rc(32'h100020, 32'h3fff_ffff, (t + 32'h1) & 32'h3fff_ffff);
        $display("test instruction trace done");
        stop_test();
    end
endmodule : test_debug_trace_buffers
